/* File: rtl/ece_cmd_exec.sv */
// Command executor of a magnetic position encoder: decodes command bytes and the
// preset pin, sequences jobs for the position, EEPROM, CRC and transfer engines.
// Assumes a byte register port and engines that answer each job with one done pulse.
// Behaviour
// [R1] Each command byte runs its assigned action; unassigned codes do nothing.
// [R2] Absolute reset recalculates position, reads multiturn, restarts converters.
// [R3] Multiturn re-read never restarts the converters; host adds absolute reset.
// [R4] Multiturn verify compares external and counted value, flags mismatch.
// [R5] Soft reset clears state, reloads EEPROM config, then redefines absolute value.
// [R6] Preset adjusts stored offsets to the preset position and updates CRC8.
// [R7] Preset-and-store also writes the new offsets to EEPROM.
// [R8] Generic transfer runs only at protection levels 0 and 2.
// [R9] A failed transfer is retried at most three more times.
// [R10] Buffer first address is the RAM source or destination.
// [R11] Length is last minus first plus one.
// [R12] Remote start address is the first location in the target device.
// [R13] Host supplies the target ID with the direction bit included.
// [R14] Event command adds exactly one to the event tally.
// [R15] Host sets protection level zero before the switch command.
// [R16] Switch writes config with target mode and level, then restores originals.
// [R17] After switch, CRC error set if cyclic check on and targets differ.
// [R18] Target mode and level take effect only at startup or soft reset; here reset clears them to zero and only soft reset loads them.
// [R19] Target mode field bits 2:0 encode the eight interface modes.
// [R20] Target protection field bits 7:6 encode the four protection levels.
// [R21] CRC verify flags mismatch; recompute stores both checksums internally.
// [R22] Clock pin commands sample data pin first; only with multiturn mode zero.
// [R23] In interface modes 2 to 7 the preset pin falling edge runs a command.
// [R24] Pin command field uses command codes; 0x00 and 0xFF do nothing.
// [R25] The event tally wraps to zero silently.
// [R26] Commands run one at a time; new ones are ignored while busy.
`timescale 1ns/100ps
module ece_cmd_exec
   import ece_pkg::*;
(
   // Clock and reset
   input  wire logic           ref_clk_i,
   input  wire logic           rst_n_i,
   // Register port
   input  wire logic           reg_wr_i,
   input  wire logic [7:0]     reg_addr_i,
   input  wire logic [7:0]     reg_wdata_i,
   output logic      [7:0]     reg_rdata_o,
   // Configuration and status from the rest of the device
   input  wire logic [2:0]     interface_mode_i,
   input  wire logic [1:0]     protection_level_i,
   input  wire logic [1:0]     multiturn_mode_i,
   input  wire logic           cyclic_check_disable_i,
   input  wire logic [2:0]     eeprom_mode_i,
   input  wire logic [1:0]     eeprom_prot_i,
   // Pins
   input  wire logic           port_a_pin_zero_i,
   input  wire logic           turn_data_pin_i,
   output logic                turn_clock_pin_o,
   // Job handshake to the engines
   output ece_pkg::ece_job_t   job_o,
   output logic                job_go_o,
   output logic                job_store_o,
   input  wire logic           job_done_i,
   input  wire logic           job_fail_i,
   input  wire logic           mt_match_i,
   input  wire logic           crc_ok_i,
   // Transfer parameters
   output logic      [7:0]     xfer_id_o,
   output logic      [7:0]     xfer_ram_first_o,
   output logic      [8:0]     xfer_len_o,
   output logic      [7:0]     xfer_remote_o,
   // Effective configuration and status
   output logic      [2:0]     active_mode_o,
   output logic      [1:0]     active_prot_o,
   output logic      [2:0]     write_mode_o,
   output logic      [1:0]     write_prot_o,
   output logic                multiturn_mismatch_flag_o,
   output logic                crc_error_flag_o,
   output logic                eeprom_fault_flag_o,
   output logic                busy_o
);
   typedef enum logic [2:0] {
      ECE_IDLE, ECE_ISSUE, ECE_WAIT, ECE_DONE
   } ece_state_t;

   ece_state_t  state_ff;
   logic [7:0]  cmd_ff;
   logic [1:0]  step_ff;
   logic [7:0]  pin_cmd_ser_ff, pin_cmd_eep_ff, remote_ff, first_ff, last_ff, id_ff;
   logic [7:0]  event_tally_ff, switch_tgt_ff;
   logic        tdata_sample_ff, tclk_ff;
   logic        mm_ff, crc_ff, eep_ff, store_ff, go_ff;
   ece_job_t    job_ff;
   logic [2:0]  act_mode_ff, wr_mode_ff;
   logic [1:0]  act_prot_ff, wr_prot_ff;
   logic [7:0]  rdata_ff;
   logic        pin_fall, launch, relaunch, finish, gave_up;
   logic [7:0]  new_cmd;
   logic        pin_valid, cmd_known;

   ece_edge_detect u_pin_edge (
      .ref_clk_i (ref_clk_i),
      .rst_n_i   (rst_n_i),
      .level_i   (port_a_pin_zero_i),
      .enable_i  (interface_mode_i >= IFM_FIRST_PIN),   // R23
      .fall_o    (pin_fall)
   );

   assign pin_valid = (pin_cmd_ser_ff != CMD_NONE) && (pin_cmd_ser_ff <= CMD_TCLK_LOW); // R24
   assign new_cmd   = (reg_wr_i && reg_addr_i == ADDR_COMMAND) ? reg_wdata_i
                    : (pin_fall && pin_valid) ? pin_cmd_ser_ff : CMD_NONE;
   assign cmd_known = (new_cmd != CMD_NONE) && (new_cmd <= CMD_TCLK_LOW);   // R1
   assign launch    = (state_ff == ECE_IDLE) && cmd_known;   // R26

   ece_xfer_retry u_retry (
      .ref_clk_i  (ref_clk_i),
      .rst_n_i    (rst_n_i),
      .start_i    (launch),
      .done_i     (job_done_i && state_ff == ECE_WAIT && job_ff == ECE_JOB_EEP_WR
                   && cmd_ff == CMD_GEN_XFER),
      .fail_i     (job_fail_i),
      .relaunch_o (relaunch),
      .finish_o   (finish),
      .gave_up_o  (gave_up)
   );

   // Writable registers.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pin_cmd_ser_ff <= RST_BYTE;
         pin_cmd_eep_ff <= RST_BYTE;
         remote_ff      <= RST_BYTE;
         first_ff       <= RST_BYTE;
         last_ff        <= RST_BYTE;
         id_ff          <= RST_BYTE;
         switch_tgt_ff  <= RST_BYTE;
      end else if (reg_wr_i) begin
         case (reg_addr_i)
            ADDR_PIN_CMD_SER:  pin_cmd_ser_ff <= reg_wdata_i;
            ADDR_PIN_CMD_EEP:  pin_cmd_eep_ff <= reg_wdata_i;
            ADDR_REMOTE_START: remote_ff      <= reg_wdata_i;   // R12
            ADDR_BUF_FIRST:    first_ff       <= reg_wdata_i;   // R10
            ADDR_BUF_LAST:     last_ff        <= reg_wdata_i;
            ADDR_TARGET_ID:    id_ff          <= reg_wdata_i;   // R13
            ADDR_SWITCH_TGT:   switch_tgt_ff  <= reg_wdata_i;   // R19 R20
            default: ;
         endcase
      end
   end

   // Event tally: command increments win over a same-cycle register write.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         event_tally_ff <= RST_BYTE;
      end else if (launch && new_cmd == CMD_EVENT) begin
         event_tally_ff <= event_tally_ff + 8'h01;   // R14 R25
      end else if (reg_wr_i && reg_addr_i == ADDR_EVENT_TALLY) begin
         event_tally_ff <= reg_wdata_i;
      end
   end

   // Sequencer.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_ff <= ECE_IDLE;
         cmd_ff   <= CMD_NONE;
         step_ff  <= 2'd0;
         job_ff   <= ECE_JOB_NONE;
         store_ff <= 1'b0;
         go_ff    <= 1'b0;
      end else begin
         go_ff <= 1'b0;
         case (state_ff)
            ECE_IDLE: begin
               if (launch) begin
                  cmd_ff   <= new_cmd;
                  step_ff  <= 2'd0;
                  state_ff <= ECE_ISSUE;
               end
            end
            ECE_ISSUE: begin
               store_ff <= 1'b0;
               state_ff <= ECE_WAIT;
               go_ff    <= 1'b1;
               case (cmd_ff)
                  CMD_WRITE_ALL, CMD_WRITE_OFF: begin
                     job_ff <= ECE_JOB_EEP_WR;
                     store_ff <= (cmd_ff == CMD_WRITE_ALL);
                  end
                  CMD_ABS_RST, CMD_NON_VER: job_ff <= ECE_JOB_ABS;   // R2
                  CMD_MT_REREAD, CMD_MT_VERIFY: job_ff <= ECE_JOB_MT_READ;   // R3 R4
                  CMD_SOFT_RST: job_ff <= (step_ff == 2'd0) ? ECE_JOB_EEP_RD
                                                               : ECE_JOB_ABS;   // R5
                  CMD_PRESET: job_ff <= (step_ff == 2'd0) ? ECE_JOB_PRESET
                                                           : ECE_JOB_CRC;   // R6
                  CMD_PRESET_ST: begin
                     job_ff <= (step_ff == 2'd0) ? ECE_JOB_PRESET
                             : (step_ff == 2'd1) ? ECE_JOB_EEP_WR : ECE_JOB_CRC;   // R7
                  end
                  CMD_GEN_XFER: begin
                     if (protection_level_i == PROT_L0 ||
                         protection_level_i == PROT_L1_BOTH) begin   // R8
                        job_ff <= ECE_JOB_EEP_WR;
                     end else begin
                        go_ff    <= 1'b0;
                        state_ff <= ECE_DONE;
                     end
                  end
                  CMD_SWITCH: job_ff <= ECE_JOB_EEP_WR;   // R16
                  CMD_CHECKSUM_VERIFY_CMD, CMD_CHECKSUM_RECOMPUTE_CMD: begin
                     job_ff   <= ECE_JOB_CRC;
                     store_ff <= (cmd_ff == CMD_CHECKSUM_RECOMPUTE_CMD);   // R21
                  end
                  default: begin
                     go_ff    <= 1'b0;
                     state_ff <= ECE_DONE;
                  end
               endcase
            end
            ECE_WAIT: begin
               if (relaunch) begin
                  state_ff <= ECE_ISSUE;   // R9
               end else if (job_done_i) begin
                  step_ff <= step_ff + 2'd1;
                  if ((cmd_ff == CMD_SOFT_RST && step_ff == 2'd0) ||
                      (cmd_ff == CMD_PRESET && step_ff == 2'd0) ||
                      (cmd_ff == CMD_PRESET_ST && step_ff != 2'd2)) begin
                     state_ff <= ECE_ISSUE;
                  end else begin
                     state_ff <= ECE_DONE;
                  end
               end
            end
            ECE_DONE: begin
               job_ff   <= ECE_JOB_NONE;
               state_ff <= ECE_IDLE;
            end
            default: state_ff <= ECE_IDLE;
         endcase
      end
   end

   // Flags and the turn clock pin.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mm_ff           <= 1'b0;
         crc_ff          <= 1'b0;
         eep_ff          <= 1'b0;
         tclk_ff         <= 1'b0;
         tdata_sample_ff <= 1'b0;
      end else begin
         if (state_ff == ECE_WAIT && job_done_i) begin
            if (cmd_ff == CMD_MT_VERIFY && !mt_match_i) mm_ff <= 1'b1;   // R4
            if (job_ff == ECE_JOB_CRC && cmd_ff == CMD_CHECKSUM_VERIFY_CMD && !crc_ok_i)
               crc_ff <= 1'b1;   // R21
            if (cmd_ff == CMD_SWITCH && !cyclic_check_disable_i &&
                (switch_tgt_ff[TGT_MODE_MSB:TGT_MODE_LSB] != interface_mode_i ||
                 switch_tgt_ff[TGT_PROT_MSB:TGT_PROT_LSB] != protection_level_i))
               crc_ff <= 1'b1;   // R17
            if (job_ff == ECE_JOB_EEP_WR && cmd_ff != CMD_GEN_XFER)
               eep_ff <= job_fail_i;
         end
         if (gave_up) eep_ff <= 1'b1;
         if (launch && multiturn_mode_i == MT_MODE_NONE &&
             (new_cmd == CMD_TCLK_HIGH || new_cmd == CMD_TCLK_LOW)) begin   // R22
            tdata_sample_ff <= turn_data_pin_i;
            tclk_ff         <= (new_cmd == CMD_TCLK_HIGH);
         end
      end
   end

   // Active configuration: cleared by reset, loaded from the EEPROM image when the soft reset EEPROM read job finishes.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         act_mode_ff <= '0;
         act_prot_ff <= '0;
         wr_mode_ff  <= '0;
         wr_prot_ff  <= '0;
      end else begin
         if (state_ff == ECE_WAIT && job_done_i && job_ff == ECE_JOB_EEP_RD) begin
            act_mode_ff <= eeprom_mode_i;   // R18
            act_prot_ff <= eeprom_prot_i;
         end
         if (state_ff == ECE_ISSUE && cmd_ff == CMD_SWITCH) begin
            wr_mode_ff <= switch_tgt_ff[TGT_MODE_MSB:TGT_MODE_LSB];   // R16
            wr_prot_ff <= switch_tgt_ff[TGT_PROT_MSB:TGT_PROT_LSB];
         end else if (state_ff == ECE_IDLE) begin
            wr_mode_ff <= interface_mode_i;
            wr_prot_ff <= protection_level_i;
         end
      end
   end

   // Read data, one cycle after the address.
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rdata_ff <= RST_BYTE;
      end else begin
         case (reg_addr_i)
            ADDR_PIN_CMD_SER:  rdata_ff <= pin_cmd_ser_ff;
            ADDR_PIN_CMD_EEP:  rdata_ff <= pin_cmd_eep_ff;
            ADDR_REMOTE_START: rdata_ff <= remote_ff;
            ADDR_BUF_FIRST:    rdata_ff <= first_ff;
            ADDR_BUF_LAST:     rdata_ff <= last_ff;
            ADDR_TARGET_ID:    rdata_ff <= id_ff;
            ADDR_SWITCH_TGT:   rdata_ff <= {switch_tgt_ff[7:1], tdata_sample_ff};
            ADDR_EVENT_TALLY:  rdata_ff <= event_tally_ff;
            default:           rdata_ff <= RST_BYTE;
         endcase
      end
   end

   assign reg_rdata_o               = rdata_ff;
   assign turn_clock_pin_o          = tclk_ff;
   assign job_o                     = job_ff;
   assign job_go_o                  = go_ff;
   assign job_store_o               = store_ff;
   assign xfer_id_o                 = id_ff;
   assign xfer_ram_first_o          = first_ff;   // R10
   assign xfer_len_o                = {1'b0, last_ff} - {1'b0, first_ff} + 9'd1;   // R11
   assign xfer_remote_o             = remote_ff;
   assign active_mode_o             = act_mode_ff;
   assign active_prot_o             = act_prot_ff;
   assign write_mode_o              = wr_mode_ff;
   assign write_prot_o              = wr_prot_ff;
   assign multiturn_mismatch_flag_o = mm_ff;
   assign crc_error_flag_o          = crc_ff;
   assign eeprom_fault_flag_o       = eep_ff;
   assign busy_o                    = (state_ff != ECE_IDLE);

   sequence event_cmd_s;
      launch && new_cmd == CMD_EVENT;
   endsequence
   property tally_step_p;
      @(posedge ref_clk_i) disable iff (!rst_n_i)
      event_cmd_s |=> event_tally_ff == $past(event_tally_ff) + 8'h01;
   endproperty
   tally_step_a: assert property (tally_step_p) else $error("tally step wrong"); // R14
   tally_wrap_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      event_cmd_s and event_tally_ff == 8'hff |=> event_tally_ff == 8'h00)
      else $error("tally no wrap"); // R25
   busy_ignore_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff != ECE_IDLE |-> !launch) else $error("launch while busy"); // R26
   unknown_cmd_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ECE_IDLE && new_cmd > CMD_TCLK_LOW |=> state_ff == ECE_IDLE)
      else $error("unknown code started"); // R1
   xfer_prot_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ECE_ISSUE && cmd_ff == CMD_GEN_XFER && protection_level_i[0]
      |=> !go_ff) else $error("transfer at bad level"); // R8
   xfer_len_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      first_ff == last_ff |-> xfer_len_o == 9'd1) else $error("length wrong"); // R11
   tclk_set_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      launch && new_cmd == CMD_TCLK_HIGH && multiturn_mode_i == MT_MODE_NONE
      |=> turn_clock_pin_o && tdata_sample_ff == $past(turn_data_pin_i))
      else $error("clock pin set wrong"); // R22
   mt_flag_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      state_ff == ECE_WAIT && job_done_i && cmd_ff == CMD_MT_VERIFY && !mt_match_i
      |=> multiturn_mismatch_flag_o) else $error("mismatch not flagged"); // R4
   reread_abs_a: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
      cmd_ff == CMD_MT_REREAD && go_ff |-> job_o != ECE_JOB_ABS)
      else $error("reread restarted converter"); // R3
endmodule : ece_cmd_exec

/* File: rtl/ece_pkg.sv */
// Package for the encoder command executor: register offsets, codes, field layouts.
// Assumes one clock domain and a byte-wide serial register port outside this block.
package ece_pkg;
   localparam logic [7:0] ADDR_PIN_CMD_SER  = 8'h25;
   localparam logic [7:0] ADDR_PIN_CMD_EEP  = 8'h30;
   localparam logic [7:0] ADDR_REMOTE_START = 8'h5b;
   localparam logic [7:0] ADDR_BUF_FIRST    = 8'h5c;
   localparam logic [7:0] ADDR_BUF_LAST     = 8'h5d;
   localparam logic [7:0] ADDR_TARGET_ID    = 8'h5e;
   localparam logic [7:0] ADDR_SWITCH_TGT   = 8'h60;
   localparam logic [7:0] ADDR_EVENT_TALLY  = 8'h73;
   localparam logic [7:0] ADDR_COMMAND      = 8'h75;

   localparam logic [7:0] CMD_NONE      = 8'h00;
   localparam logic [7:0] CMD_WRITE_ALL = 8'h01;
   localparam logic [7:0] CMD_WRITE_OFF = 8'h02;
   localparam logic [7:0] CMD_ABS_RST   = 8'h03;
   localparam logic [7:0] CMD_NON_VER   = 8'h04;
   localparam logic [7:0] CMD_MT_REREAD = 8'h05;
   localparam logic [7:0] CMD_MT_VERIFY = 8'h06;
   localparam logic [7:0] CMD_SOFT_RST  = 8'h07;
   localparam logic [7:0] CMD_PRESET    = 8'h08;
   localparam logic [7:0] CMD_PRESET_ST = 8'h09;
   localparam logic [7:0] CMD_GEN_XFER  = 8'h0a;
   localparam logic [7:0] CMD_EVENT     = 8'h0b;
   localparam logic [7:0] CMD_SWITCH    = 8'h0c;
   localparam logic [7:0] CMD_CHECKSUM_VERIFY_CMD   = 8'h0d;
   localparam logic [7:0] CMD_CHECKSUM_RECOMPUTE_CMD  = 8'h0e;
   localparam logic [7:0] CMD_TCLK_HIGH = 8'h0f;
   localparam logic [7:0] CMD_TCLK_LOW  = 8'h10;

   localparam logic [1:0] PROT_L0       = 2'h0;
   localparam logic [1:0] PROT_L1_BOTH  = 2'h2;
   localparam logic [2:0] IFM_FIRST_PIN = 3'h2;
   localparam logic [1:0] MT_MODE_NONE  = 2'h0;
   localparam int         TGT_MODE_LSB  = 0;
   localparam int         TGT_MODE_MSB  = 2;
   localparam int         TGT_PROT_LSB  = 6;
   localparam int         TGT_PROT_MSB  = 7;
   localparam int         TDATA_BIT     = 0;
   localparam logic [1:0] XFER_RETRIES  = 2'h3;
   localparam logic [7:0] RST_BYTE      = 8'h00;

   // Step kinds issued to the external sequencers.
   typedef enum logic [2:0] {
      ECE_JOB_NONE, ECE_JOB_ABS, ECE_JOB_MT_READ, ECE_JOB_PRESET,
      ECE_JOB_EEP_WR, ECE_JOB_EEP_RD, ECE_JOB_CRC
   } ece_job_t;
endpackage : ece_pkg

/* File: rtl/ece_edge_detect.sv */
// Falling edge detector for the preset pin.
// Assumes the pin is already synchronous to the clock.
`timescale 1ns/100ps
module ece_edge_detect (
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Pin
   input  wire logic level_i,
   input  wire logic enable_i,
   output logic      fall_o
);
   logic prev_ff;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         prev_ff <= 1'b1;
      end else begin
         prev_ff <= level_i;
      end
   end
   assign fall_o = enable_i & prev_ff & ~level_i;
endmodule : ece_edge_detect

/* File: rtl/ece_xfer_retry.sv */
// Retry counter for generic transfers: a failed attempt relaunches up to a limit.
// Assumes the transfer engine answers each launch with one done pulse and a fail flag.
`timescale 1ns/100ps
module ece_xfer_retry
   import ece_pkg::*;
(
   // Clock and reset
   input  wire logic ref_clk_i,
   input  wire logic rst_n_i,
   // Control
   input  wire logic start_i,
   input  wire logic done_i,
   input  wire logic fail_i,
   output logic      relaunch_o,
   output logic      finish_o,
   output logic      gave_up_o
);
   logic [1:0] tries_ff;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tries_ff <= '0;
      end else if (start_i) begin
         tries_ff <= '0;
      end else if (relaunch_o) begin
         tries_ff <= tries_ff + 2'd1;
      end
   end
   assign relaunch_o = done_i & fail_i & (tries_ff != XFER_RETRIES);
   assign finish_o   = done_i & ~relaunch_o;
   assign gave_up_o  = finish_o & fail_i;
endmodule : ece_xfer_retry

/* File: tb/ece_engine_model.sv */
// Behavioural model of the position, EEPROM, CRC and transfer engines on the job port.
// Assumes one done pulse per go pulse; status levels mean something only with done.
`timescale 1ns/100ps
module ece_engine_model (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       rst_n_i,
   // Job handshake and answer settings
   input  wire logic       job_go_i,
   input  wire logic [3:0] delay_i,
   input  wire logic       fail_i,
   input  wire logic       match_i,
   input  wire logic       ok_i,
   output logic            job_done_o,
   output logic            job_fail_o,
   output logic            mt_match_o,
   output logic            crc_ok_o,
   output logic [7:0]      go_count_o
);
   logic [3:0] wait_ff;
   logic       run_ff;
   logic       tog_ff;
   always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wait_ff    <= 4'h0;
         run_ff     <= 1'b0;
         job_done_o <= 1'b0;
         go_count_o <= 8'h00;
         tog_ff     <= 1'b0;
      end else begin
         tog_ff     <= ~tog_ff;
         job_done_o <= 1'b0;
         if (job_go_i) begin
            run_ff     <= 1'b1;
            wait_ff    <= delay_i;
            go_count_o <= go_count_o + 8'h01;
         end else if (run_ff && wait_ff == 4'h0) begin
            run_ff     <= 1'b0;
            job_done_o <= 1'b1;
         end else if (run_ff) begin
            wait_ff <= wait_ff - 4'h1;
         end
      end
   end
   // Outside done the levels toggle, so a design that samples them late sees junk.
   assign job_fail_o = job_done_o ? fail_i : tog_ff;
   assign mt_match_o = job_done_o ? match_i : tog_ff;
   assign crc_ok_o   = job_done_o ? ok_i : ~tog_ff;
endmodule : ece_engine_model

/* File: tb/encoder_command_executor_tb.sv */
// Self-checking bench for the command executor; expected values go through a queue.
// Assumes the engine model answers every job and the bench plays the host.
`timescale 1ns/100ps
module encoder_command_executor_tb;
   import ece_pkg::*;
   logic clk = 0, rst_n = 0, wr_en = 0, ccd = 1, pin = 1, tdata = 0, fl = 0, mt = 1, ok = 1;
   logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, gcnt, f, l;
   logic [2:0] imode = 3'h0, emode = 3'h0, amode;
   logic [1:0] plevel = 2'h0, mtmode = 2'h0, eprot = 2'h0, aprot;
   logic [3:0] dly = 4'h0;
   logic [8:0] len;
   logic tclk, go, done, jfail, jmatch, jok, mism, crce, eepf, busy;
   ece_job_t job;
   logic [31:0] seed = 32'hea3d_4b8e, r;
   int num_errors = 0, tests_run = 0, cyc = 0, g;
   logic [8:0] exp_q [$];
   int sel_q [$];
   string nm [11] = '{"rdata", "len", "busy", "mism", "crce", "eepf", "tclk", "amode",
                      "gocnt", "go", "aprot"};
   logic [7:0] codes [7] = '{CMD_ABS_RST, CMD_MT_REREAD, CMD_SOFT_RST, CMD_PRESET,
                             CMD_PRESET_ST, CMD_CHECKSUM_VERIFY_CMD, CMD_CHECKSUM_RECOMPUTE_CMD};
   int njob [7] = '{1, 1, 2, 2, 3, 1, 1};
   event smp;
   always #2 clk = ~clk;
   ece_cmd_exec ece_cmd_exec_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .reg_wr_i(wr_en),
      .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .interface_mode_i(imode),
      .protection_level_i(plevel), .multiturn_mode_i(mtmode), .cyclic_check_disable_i(ccd),
      .eeprom_mode_i(emode), .eeprom_prot_i(eprot), .port_a_pin_zero_i(pin),
      .turn_data_pin_i(tdata), .turn_clock_pin_o(tclk), .job_o(job), .job_go_o(go),
      .job_store_o(), .job_done_i(done), .job_fail_i(jfail), .mt_match_i(jmatch),
      .crc_ok_i(jok), .xfer_id_o(), .xfer_ram_first_o(), .xfer_len_o(len), .xfer_remote_o(),
      .active_mode_o(amode), .active_prot_o(aprot), .write_mode_o(), .write_prot_o(),
      .multiturn_mismatch_flag_o(mism), .crc_error_flag_o(crce),
      .eeprom_fault_flag_o(eepf), .busy_o(busy));
   ece_engine_model ece_engine_model_inst (.ref_clk_i(clk), .rst_n_i(rst_n), .job_go_i(go),
      .delay_i(dly), .fail_i(fl), .match_i(mt), .ok_i(ok), .job_done_o(done),
      .job_fail_o(jfail), .mt_match_o(jmatch), .crc_ok_o(jok), .go_count_o(gcnt));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [8:0] obs(int s);
      case (s)
         0: return {1'b0, rdata};
         1: return len;
         2: return {8'h00, busy};
         3: return {8'h00, mism};
         4: return {8'h00, crce};
         5: return {8'h00, eepf};
         6: return {8'h00, tclk};
         7: return {6'h00, amode};
         8: return {1'b0, gcnt};
         9: return {8'h00, go};
         default: return {7'h00, aprot};
      endcase
   endfunction : obs
   task automatic cmp(string n, logic [8:0] seen, logic [8:0] e);
      tests_run++;
      if (seen !== e) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", n, e, seen);
      end
   endtask : cmp
   task automatic chk(int s, logic [8:0] e);
      exp_q.push_back(e);
      sel_q.push_back(s);
      -> smp;
   endtask : chk
   // The watcher drains everything noted so far against the settled outputs.
   initial forever begin
      @(smp);
      while (exp_q.size() > 0) cmp(nm[sel_q[0]], obs(sel_q.pop_front()), exp_q.pop_front());
   end
   task automatic wr(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      #1 {wr_en, addr, wdata} = {1'b1, a, d};
      @(posedge clk);
      #1 wr_en = 1'b0;
   endtask : wr
   task automatic rd(logic [7:0] a);
      @(posedge clk);
      #1 addr = a;
      @(posedge clk);
      #1;
   endtask : rd
   task automatic idle();
      for (int k = 0; k < 300 && busy !== 1'b0; k++) begin
         @(posedge clk);
         #1;
      end
   endtask : idle
   task automatic cmd(logic [7:0] c);
      g = gcnt;
      wr(ADDR_COMMAND, c);
      idle();
   endtask : cmd
   task automatic fall();
      @(posedge clk);
      #1 pin = 1'b0;
      repeat (3) @(posedge clk);
      #1 pin = 1'b1;
      repeat (2) @(posedge clk);
      idle();
   endtask : fall
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : finish_test
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      repeat (6) @(posedge clk);
      #1 rst_n = 1'b1;
      rd(ADDR_EVENT_TALLY);
      chk(0, 9'h000);
      for (int i = 0; i < 4; i++) begin
         r = xs();
         wr(ADDR_REMOTE_START + 8'(i), r[7:0]);
         rd(ADDR_REMOTE_START + 8'(i));
         chk(0, {1'b0, r[7:0]});
      end
      r = xs();
      f = {1'b0, r[6:0]};
      l = f + {1'b0, r[14:8]};
      wr(ADDR_BUF_FIRST, f);
      wr(ADDR_BUF_LAST, l);
      chk(1, {1'b0, l - f} + 9'h001);
      wr(ADDR_BUF_LAST, f);
      chk(1, 9'h001);
      wr(ADDR_EVENT_TALLY, 8'hff);
      wr(ADDR_COMMAND, CMD_EVENT);
      chk(2, 9'h001);
      idle();
      rd(ADDR_EVENT_TALLY);
      chk(0, 9'h000);
      foreach (codes[i]) begin
         if (codes[i] == CMD_SOFT_RST) {emode, eprot, dly} = {3'h3, 2'h2, 4'h5};
         cmd(codes[i]);
         chk(8, 9'(g + njob[i]));
      end
      chk(7, 9'h003);
      chk(10, 9'h002);
      {mt, dly} = {1'b0, 4'h9};
      wr(ADDR_COMMAND, CMD_MT_VERIFY);
      wr(ADDR_COMMAND, CMD_EVENT);
      idle();
      chk(3, 9'h001);
      rd(ADDR_EVENT_TALLY);
      chk(0, 9'h000);
      wr(ADDR_COMMAND, 8'h11);
      chk(2, 9'h000);
      for (int lv = 0; lv < 4; lv++) begin
         plevel = 2'(lv);
         cmd(CMD_GEN_XFER);
         chk(8, 9'(g + ((lv == 0 || lv == 2) ? 1 : 0)));
      end
      {fl, dly, plevel} = {1'b1, 4'h0, 2'h0};
      cmd(CMD_GEN_XFER);
      chk(8, 9'(g + 4));
      chk(5, 9'h001);
      {fl, plevel, imode} = {1'b0, 2'h0, 3'h1};
      wr(ADDR_SWITCH_TGT, 8'h42);
      cmd(CMD_SWITCH);
      chk(4, 9'h000);
      ccd = 1'b0;
      cmd(CMD_SWITCH);
      chk(4, 9'h001);
      chk(7, 9'h003);
      {mtmode, tdata} = {2'h1, 1'b1};
      cmd(CMD_TCLK_HIGH);
      chk(6, 9'h000);
      mtmode = 2'h0;
      cmd(CMD_TCLK_HIGH);
      chk(6, 9'h001);
      rd(ADDR_SWITCH_TGT);
      chk(0, 9'h043);
      wr(ADDR_PIN_CMD_SER, CMD_EVENT);
      fall();
      rd(ADDR_EVENT_TALLY);
      chk(0, 9'h000);
      imode = 3'h3;
      fall();
      rd(ADDR_EVENT_TALLY);
      chk(0, 9'h001);
      wr(ADDR_PIN_CMD_SER, 8'hff);
      fall();
      rd(ADDR_EVENT_TALLY);
      chk(0, 9'h001);
      @(posedge clk);
      finish_test();
   end
endmodule : encoder_command_executor_tb
